// ==== hw/spi_eeprom_core.sv ====
// Purpose: serial command logic of a 512 x 8 serial eeprom
// Assumes: pins are asynchronous to ref_clk; sck at most 2.5 MHz for 20 MHz ref_clk
// Notes:   srst stands in for power-up; the array itself is held in byte_mem
// What this block does
// - sample si rising, change so falling
// - address msb from opcode bit 3
// - stream bytes, address advances per byte
// - read address wraps top to zero
// - select rise ends read output
// - status opcode shifts status byte out
// - more clocks after latch-set void it
// - up to four bytes per page write
// - page pointer wraps inside its page
// - commit only on a byte boundary
// - status readable during write, busy one
// - pause input suspends the transfer
// - after reset wait for select fall
// - latch clear at reset, set by opcode
// - opcode encodings
// - status byte layout, all ones busy
// - protect levels block array writes
// - latch clears when write cycle ends
`timescale 1ns/100ps
module spi_eeprom_core #(
    parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input  wire logic       ref_clk,       // system clock, 20 MHz
    input  wire logic       srst,          // synchronous reset, active high
    input  wire logic       sck,           // serial shift clock pin
    input  wire logic       cs_n,          // device select pin, active low
    input  wire logic       si,            // serial data in pin
    input  wire logic       hold_n,        // pause pin, active low
    output logic            so,            // serial data out
    output logic            so_oe,         // high while so is driven
    output logic            write_busy,    // internal write cycle running
    output logic            write_latch,   // write-enable latch state
    output logic [1:0]      protect_level  // protect-level bits
);

    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        PH_IDLE    = 9'h001,
        PH_CMD     = 9'h002,
        PH_ADDR    = 9'h004,
        PH_RDATA   = 9'h008,
        PH_SREAD   = 9'h010,
        PH_WDATA   = 9'h020,
        PH_SWDATA  = 9'h040,
        PH_LATCH   = 9'h080,
        PH_IGNORE  = 9'h100
    } phase_t;

    typedef struct packed {
        logic [2:0]       sck_sy;
        logic [2:0]       cs_sy;
        logic [1:0]       si_sy;
        logic [1:0]       hold_sy;
        logic             armed;
        phase_t           phase;
        logic [2:0]       bit_cnt;
        logic [7:0]       in_sh;
        logic [7:0]       cmd;
        logic [8:0]       addr;
        logic             latch;
        logic [1:0]       bp;
        logic             busy;
        logic [CNT_W-1:0] busy_cnt;
        logic             writing;
        logic [1:0]       wr_idx;
        logic [6:0]       pg_base;
        logic [1:0]       pg_ptr;
        logic [3:0][7:0]  pg_data;
        logic [3:0]       pg_valid;
        logic             byte_done;
        logic [7:0]       sw_data;
        logic             fetch_pend;
        logic [1:0][7:0]  fb_data;
        logic             fb_wp;
        logic             fb_rp;
        logic [1:0]       fb_cnt;
        logic [7:0]       out_sh;
        logic [2:0]       out_left;
        logic             out_on;
        logic             so;
    } core_t;

    core_t q_ff;
    core_t nxt_q;

    logic       sck_rise;
    logic       sck_fall;
    logic       cs_high;
    logic       cs_rise;
    logic       cs_fall;
    logic       hold_ok;
    logic       rise;
    logic       fall;
    logic [7:0] in_byte;
    logic [7:0] status_byte;
    logic [7:0] load_byte;
    logic       fb_in_valid;
    logic       fb_in_ready;
    logic       fb_out_valid;
    logic       fb_out_ready;
    logic       mem_we;
    logic [8:0] mem_wa;
    logic [7:0] mem_wd;
    logic       mem_re;
    logic [7:0] mem_rd;

    function automatic logic page_protected(input logic [6:0] base, input logic [1:0] lvl);
        logic [8:0] a;
        a = {base, 2'b00};
        unique case (lvl)
            eeprom_pkg::PROT_NONE:    page_protected = 1'b0;
            eeprom_pkg::PROT_QUARTER: page_protected = (a >= eeprom_pkg::QUARTER_BASE);
            eeprom_pkg::PROT_HALF:    page_protected = (a >= eeprom_pkg::HALF_BASE);
            eeprom_pkg::PROT_ALL:     page_protected = 1'b1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // pin sampling and edge finding
    // ------------------------------------------------------------
    // pins pass two flops; the third stage only feeds the edge compare
    assign sck_rise = q_ff.sck_sy[1] & ~q_ff.sck_sy[2];
    assign sck_fall = ~q_ff.sck_sy[1] & q_ff.sck_sy[2];
    assign cs_high  = q_ff.cs_sy[1];
    assign cs_rise  = q_ff.cs_sy[1] & ~q_ff.cs_sy[2];
    assign cs_fall  = ~q_ff.cs_sy[1] & q_ff.cs_sy[2];
    assign hold_ok  = q_ff.hold_sy[1];
    assign rise     = sck_rise & hold_ok & ~cs_high;
    assign fall     = sck_fall & hold_ok & ~cs_high;
    assign in_byte  = {q_ff.in_sh[6:0], q_ff.si_sy[1]};

    assign status_byte = q_ff.busy ? eeprom_pkg::STATUS_DURING_WRITE :
                         {4'h0, q_ff.bp, q_ff.latch, q_ff.busy};

    // ------------------------------------------------------------
    // read-ahead buffer handshakes
    // ------------------------------------------------------------
    // the buffer counts the fetch in flight so a stalled shifter
    // holds the fetcher off instead of dropping a byte
    assign fb_in_valid  = q_ff.fetch_pend & (q_ff.phase == PH_RDATA) & ~cs_rise;
    assign fb_in_ready  = ({1'b0, q_ff.fb_cnt} + {2'b00, q_ff.fetch_pend}) < 3'd2;
    assign fb_out_valid = (q_ff.fb_cnt != 2'd0);
    assign fb_out_ready = fall & (q_ff.phase == PH_RDATA) & (q_ff.out_left == 3'd0);
    assign mem_re       = (q_ff.phase == PH_RDATA) & ~q_ff.fetch_pend & fb_in_ready
                          & ~cs_high;
    assign load_byte    = (q_ff.phase == PH_SREAD) ? status_byte :
                          (fb_out_valid ? q_ff.fb_data[q_ff.fb_rp] : 8'h00);

    // ------------------------------------------------------------
    // array write port, fed from the page buffer
    // ------------------------------------------------------------
    assign mem_we = q_ff.writing & q_ff.pg_valid[q_ff.wr_idx];
    assign mem_wa = {q_ff.pg_base, q_ff.wr_idx};
    assign mem_wd = q_ff.pg_data[q_ff.wr_idx];

    byte_mem #(
        .DEPTH   (eeprom_pkg::MEM_DEPTH),
        .AW      (eeprom_pkg::ADDR_W),
        .DW      (eeprom_pkg::DATA_W)
    ) u_array (
        .clk     (ref_clk),
        .wr_en   (mem_we),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_en   (mem_re),
        .rd_addr (q_ff.addr),
        .rd_data (mem_rd)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_q         = q_ff;
        nxt_q.sck_sy  = {q_ff.sck_sy[1:0], sck};
        nxt_q.cs_sy   = {q_ff.cs_sy[1:0], cs_n};
        nxt_q.si_sy   = {q_ff.si_sy[0], si};
        nxt_q.hold_sy = {q_ff.hold_sy[0], hold_n};
        if (cs_high) begin
            nxt_q.armed = 1'b1;
        end

        // self-timed write cycle
        if (q_ff.writing) begin
            nxt_q.wr_idx = q_ff.wr_idx + 2'd1;
            if (q_ff.wr_idx == 2'd3) begin
                nxt_q.writing = 1'b0;
            end
        end
        if (q_ff.busy) begin
            if (q_ff.busy_cnt == '0) begin
                nxt_q.busy  = 1'b0;
                nxt_q.latch = 1'b0;
            end else begin
                nxt_q.busy_cnt = q_ff.busy_cnt - CNT_W'(1);
            end
        end

        // read-ahead fetch and buffer
        nxt_q.fetch_pend = mem_re;
        if (mem_re) begin
            nxt_q.addr = q_ff.addr + 9'h001;
        end
        if (fb_in_valid) begin
            nxt_q.fb_data[q_ff.fb_wp] = mem_rd;
            nxt_q.fb_wp = ~q_ff.fb_wp;
        end
        if (fb_out_ready & fb_out_valid) begin
            nxt_q.fb_rp = ~q_ff.fb_rp;
        end
        nxt_q.fb_cnt = q_ff.fb_cnt + {1'b0, fb_in_valid}
                       - {1'b0, fb_out_ready & fb_out_valid};

        // output shifter, changes only on falling sck
        if (fall & ((q_ff.phase == PH_RDATA) | (q_ff.phase == PH_SREAD))) begin
            nxt_q.out_on = 1'b1;
            if (q_ff.out_left == 3'd0) begin
                nxt_q.so       = load_byte[7];
                nxt_q.out_sh   = {load_byte[6:0], 1'b0};
                nxt_q.out_left = 3'd7;
            end else begin
                nxt_q.so       = q_ff.out_sh[7];
                nxt_q.out_sh   = {q_ff.out_sh[6:0], 1'b0};
                nxt_q.out_left = q_ff.out_left - 3'd1;
            end
        end

        // input shifter, samples only on rising sck
        if (rise) begin
            nxt_q.in_sh   = in_byte;
            nxt_q.bit_cnt = q_ff.bit_cnt + 3'd1;
            unique case (q_ff.phase)
                PH_CMD: begin
                    if (q_ff.bit_cnt == 3'd7) begin
                        nxt_q.cmd = in_byte;
                        nxt_q.phase = PH_IGNORE;
                        if ((in_byte[7:4] == eeprom_pkg::ARRAY_CMD_HIGH)
                            && (in_byte[2:0] == eeprom_pkg::ARRAY_READ_LOW)) begin
                            nxt_q.addr[8] = in_byte[eeprom_pkg::CMD_ADDRESS_MSB_POS];
                            nxt_q.phase   = PH_ADDR;
                        end else if ((in_byte[7:4] == eeprom_pkg::ARRAY_CMD_HIGH)
                            && (in_byte[2:0] == eeprom_pkg::ARRAY_WRITE_LOW)) begin
                            if (q_ff.latch & ~q_ff.busy) begin
                                nxt_q.addr[8] = in_byte[eeprom_pkg::CMD_ADDRESS_MSB_POS];
                                nxt_q.phase   = PH_ADDR;
                            end
                        end else if (in_byte == eeprom_pkg::SET_WRITE_LATCH_CMD) begin
                            nxt_q.phase = PH_LATCH;
                        end else if (in_byte == eeprom_pkg::CLEAR_WRITE_LATCH_CMD) begin
                            nxt_q.latch = 1'b0;
                        end else if (in_byte == eeprom_pkg::STATUS_READ_CMD) begin
                            nxt_q.phase = PH_SREAD;
                        end else if (in_byte == eeprom_pkg::STATUS_WRITE_CMD) begin
                            if (q_ff.latch & ~q_ff.busy) begin
                                nxt_q.phase     = PH_SWDATA;
                                nxt_q.byte_done = 1'b0;
                            end
                        end
                    end
                end
                PH_ADDR: begin
                    if (q_ff.bit_cnt == 3'd7) begin
                        nxt_q.addr[7:0] = in_byte;
                        if (q_ff.cmd[2:0] == eeprom_pkg::ARRAY_READ_LOW) begin
                            nxt_q.phase = PH_RDATA;
                        end else begin
                            nxt_q.phase     = PH_WDATA;
                            nxt_q.pg_base   = {q_ff.addr[8], in_byte[7:2]};
                            nxt_q.pg_ptr    = in_byte[1:0];
                            nxt_q.pg_valid  = 4'h0;
                            nxt_q.byte_done = 1'b0;
                        end
                    end
                end
                PH_WDATA: begin
                    nxt_q.byte_done = 1'b0;
                    if (q_ff.bit_cnt == 3'd7) begin
                        nxt_q.pg_data[q_ff.pg_ptr]  = in_byte;
                        nxt_q.pg_valid[q_ff.pg_ptr] = 1'b1;
                        nxt_q.pg_ptr    = q_ff.pg_ptr + 2'd1;
                        nxt_q.byte_done = 1'b1;
                    end
                end
                PH_SWDATA: begin
                    nxt_q.byte_done = 1'b0;
                    if (q_ff.bit_cnt == 3'd7) begin
                        nxt_q.sw_data   = in_byte;
                        nxt_q.byte_done = 1'b1;
                    end
                end
                PH_LATCH: begin
                    nxt_q.phase = PH_IGNORE;
                end
                PH_IDLE, PH_RDATA, PH_SREAD, PH_IGNORE: begin
                end
                default: begin
                    nxt_q.phase = PH_IGNORE;
                end
            endcase
        end

        // select edges override the serial work above
        if (cs_rise) begin
            nxt_q.phase      = PH_IDLE;
            nxt_q.out_on     = 1'b0;
            nxt_q.out_left   = 3'd0;
            nxt_q.fetch_pend = 1'b0;
            nxt_q.fb_cnt     = 2'd0;
            nxt_q.fb_rp      = 1'b0;
            nxt_q.fb_wp      = 1'b0;
            if (q_ff.phase == PH_LATCH) begin
                nxt_q.latch = 1'b1;
            end
            if ((q_ff.phase == PH_WDATA) & q_ff.byte_done
                & ~page_protected(q_ff.pg_base, q_ff.bp)) begin
                nxt_q.busy     = 1'b1;
                nxt_q.busy_cnt = CNT_LOAD;
                nxt_q.writing  = 1'b1;
                nxt_q.wr_idx   = 2'd0;
            end
            if ((q_ff.phase == PH_SWDATA) & q_ff.byte_done) begin
                nxt_q.bp = {q_ff.sw_data[eeprom_pkg::PROTECT_LEVEL_HIGH_POS],
                            q_ff.sw_data[eeprom_pkg::PROTECT_LEVEL_LOW_POS]};
                nxt_q.busy     = 1'b1;
                nxt_q.busy_cnt = CNT_LOAD;
            end
        end else if (cs_fall & q_ff.armed) begin
            nxt_q.phase    = PH_CMD;
            nxt_q.bit_cnt  = 3'd0;
            nxt_q.out_left = 3'd0;
            nxt_q.out_on   = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q_ff         <= '0;
            q_ff.phase   <= PH_IDLE;
            q_ff.latch   <= 1'b0;
            q_ff.bp      <= eeprom_pkg::PROTECT_RESET;
            q_ff.hold_sy <= 2'b11;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pause and deselect release the pin two ref_clk edges after the pin changes, without waiting for sck
    assign so            = q_ff.so;
    assign so_oe         = q_ff.out_on & ~cs_high & hold_ok;
    assign write_busy    = q_ff.busy;
    assign write_latch   = q_ff.latch;
    assign protect_level = q_ff.bp;

endmodule

// ==== hw/eeprom_pkg.sv ====
// Purpose: shared constants for the serial eeprom command logic
// Assumes: 20 MHz system clock, 512 x 8 array, 4-byte pages
// Notes:   opcodes are sent most significant bit first
package eeprom_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int          MEM_DEPTH    = 512;
    localparam int          ADDR_W       = 9;
    localparam int          DATA_W       = 8;
    localparam int          PAGE_BYTES   = 4;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0]  SET_WRITE_LATCH_CMD   = 8'h06;
    localparam logic [7:0]  CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0]  STATUS_READ_CMD       = 8'h05;
    localparam logic [7:0]  STATUS_WRITE_CMD      = 8'h01;
    localparam logic [3:0]  ARRAY_CMD_HIGH        = 4'h0;
    localparam logic [2:0]  ARRAY_READ_LOW        = 3'h3;
    localparam logic [2:0]  ARRAY_WRITE_LOW       = 3'h2;
    localparam int          CMD_ADDRESS_MSB_POS   = 3;

    // ------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------
    localparam int          WRITE_BUSY_POS        = 0;
    localparam int          WRITE_LATCH_POS       = 1;
    localparam int          PROTECT_LEVEL_LOW_POS = 2;
    localparam int          PROTECT_LEVEL_HIGH_POS = 3;
    localparam logic [7:0]  STATUS_DURING_WRITE   = 8'hff;
    localparam logic [1:0]  PROTECT_RESET         = 2'h0;

    // ------------------------------------------------------------
    // protected ranges
    // ------------------------------------------------------------
    localparam logic [1:0]  PROT_NONE    = 2'h0;
    localparam logic [1:0]  PROT_QUARTER = 2'h1;
    localparam logic [1:0]  PROT_HALF    = 2'h2;
    localparam logic [1:0]  PROT_ALL     = 2'h3;
    localparam logic [8:0]  QUARTER_BASE = 9'h180;
    localparam logic [8:0]  HALF_BASE    = 9'h100;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          WRITE_TIME_MS  = 10;
    localparam int          WRITE_CYCLES   = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          SYNC_STAGES    = 3;

endpackage

// ==== hw/byte_mem.sv ====
// Purpose: two-port byte array with registered read data
// Assumes: one write port and one read port on the same clock
// Notes:   array contents are not reset, as a real array is not
`timescale 1ns/100ps
module byte_mem #(
    parameter int DEPTH  = eeprom_pkg::MEM_DEPTH,
    parameter int AW     = eeprom_pkg::ADDR_W,
    parameter int DW     = eeprom_pkg::DATA_W
) (
    input  wire logic          clk,      // system clock
    input  wire logic          wr_en,    // write strobe
    input  wire logic [AW-1:0] wr_addr,  // write address
    input  wire logic [DW-1:0] wr_data,  // write data
    input  wire logic          rd_en,    // read strobe
    input  wire logic [AW-1:0] rd_addr,  // read address
    output logic      [DW-1:0] rd_data   // read data, one cycle after rd_en
);

    logic [DW-1:0] mem_ff [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem_ff[rd_addr];
        end
    end

endmodule

// ==== testbench/spi_eeprom_core_properties.sv ====
// Purpose: port checks for spi_eeprom_core
// Assumes: pins pass a two-stage synchroniser; sck and cs_n add a third stage for edge finding
// Notes:   bound from the bench top file
`timescale 1ns/100ps
module spi_eeprom_core_properties #(
    parameter int unsigned WRITE_CYCLES = 50
) (
    input wire logic       ref_clk,       // clock
    input wire logic       srst,          // reset
    input wire logic       sck,           // shift clock
    input wire logic       cs_n,          // select
    input wire logic       hold_n,        // pause
    input wire logic       so,            // serial out
    input wire logic       so_oe,         // out enable
    input wire logic       write_busy,    // busy flag
    input wire logic       write_latch,   // latch flag
    input wire logic [1:0] protect_level  // protect bits
);
    int unsigned busy_cnt_ff;
    always_ff @(posedge ref_clk) begin
        if (srst || !write_busy)
            busy_cnt_ff <= 0;
        else
            busy_cnt_ff <= busy_cnt_ff + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    reset_state_a: assert property ($fell(srst) |-> !so_oe && !write_busy && !write_latch)
        else $error("outputs not idle after reset");
    deselect_quiet_a: assert property (cs_n [*6] |-> !so_oe)
        else $error("so driven while deselected");
    pause_quiet_a: assert property (!hold_n [*6] |-> !so_oe)
        else $error("so driven while paused");
    so_steady_a: assert property (sck [*3] |-> $stable(so))
        else $error("so moved while sck high");
    busy_length_a: assert property ($fell(write_busy) |-> busy_cnt_ff == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_needs_latch_a: assert property ($rose(write_busy) |-> $past(write_latch) && cs_n)
        else $error("write cycle without latch");
    latch_auto_clear_a: assert property ($fell(write_busy) |-> ##[0:1] !write_latch)
        else $error("latch kept after write cycle");
    latch_set_deselect_a: assert property ($rose(write_latch) |-> cs_n)
        else $error("latch set inside a frame");
    cover property ($fell(write_busy));
    cover property ($rose(so_oe));
    cover property ($changed(protect_level));
endmodule

// ==== testbench/spi_host_model.sv ====
// Purpose: behavioural host controller on the eeprom pins
// Assumes: mode 0, 400 ns shift clock, msb first
// Notes:   pin changes land 1 ns after a ref_clk edge
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic ref_clk,  // alignment only
    input  wire logic so,       // device data
    input  wire logic so_oe,    // device drives so
    output logic      sck,      // idle low
    output logic      cs_n,     // select
    output logic      si,       // data to device
    output logic      hold_n    // pause
);
    logic rx_last = 1'b0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic sel();
        @(posedge ref_clk);
        #1 cs_n = 1'b0;
        #200;
    endtask
    task automatic desel();
        #200 cs_n = 1'b1;
        si = ~si;
        #400;
    endtask
    // a released so reads back as the inverse of the last bit, never a tidy level
    task automatic xfer(input logic [7:0] tx, input int hi, input int lo,
                        inout logic [7:0] rx);
        for (int i = hi; i >= lo; i--) begin
            si = tx[i];
            #200 sck = 1'b1;
            #190 rx[i] = so_oe ? so : ~rx_last;
            rx_last = rx[i];
            #10 sck = 1'b0;
        end
    endtask
    // the shared clock keeps running for another device during the pause
    task automatic pause();
        #100 hold_n = 1'b0;
        repeat (2) begin
            #200 sck = 1'b1;
            #200 sck = 1'b0;
        end
        #200 hold_n = 1'b1;
        #200;
    endtask
endmodule

// ==== testbench/spi_eeprom_core_bench.sv ====
// Purpose: self-checking bench for spi_eeprom_core
// Assumes: write cycle shortened to WR_CYC clocks
// Notes:   shadow holds what the array should contain
`timescale 1ns/100ps
module spi_eeprom_core_bench;
    localparam int WR_CYC = 400;
    logic       ref_clk, srst, sck, cs_n, si, hold_n, so, so_oe;
    logic       write_busy, write_latch;
    logic [1:0] protect_level;
    logic [7:0] shadow [512];
    logic [7:0] rx, st;
    int         n_mismatch = 0;
    int         n_tests = 0;
    int         cyc = 0;
    spi_eeprom_core #(.WRITE_CYCLES(WR_CYC)) dut (.ref_clk(ref_clk), .srst(srst), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe),
        .write_busy(write_busy), .write_latch(write_latch), .protect_level(protect_level));
    spi_host_model host (.ref_clk(ref_clk), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
        .si(si), .hold_n(hold_n));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // about 15k clocks expected
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    function automatic logic [7:0] dat(input logic [8:0] a, input int i);
        return a[7:0] ^ (8'h35 * 8'(i + 1));
    endfunction
    task automatic cmd(input logic [7:0] op);
        host.sel();
        host.xfer(op, 7, 0, rx);
        host.desel();
    endtask
    task automatic status();
        host.sel();
        host.xfer(8'h05, 7, 0, rx);
        host.xfer(8'h00, 7, 0, st);
        host.desel();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 1000 && write_busy !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(write_busy, 1'b0, "busy end");
    endtask
    task automatic sw(input logic [1:0] lv);
        cmd(8'h06);
        host.sel();
        host.xfer(8'h01, 7, 0, rx);
        host.xfer({4'h0, lv, 2'h0}, 7, 0, rx);
        host.desel();
        chk(write_busy, 1'b1, "status write busy");
        wait_idle();
        status();
        chk(st, {4'h0, lv, 2'h0}, "status");
        chk({6'h0, protect_level}, {6'h0, lv}, "protect bits");
    endtask
    // mode 0: latch set first; 1: none; 2: latch set inside the same frame
    task automatic wr(input logic [8:0] a, input int n, input int tail, input bit ok,
                      input int mode);
        logic l;
        if (mode == 0)
            cmd(8'h06);
        l = write_latch;
        host.sel();
        if (mode == 2)
            host.xfer(8'h06, 7, 0, rx);
        host.xfer({4'h0, a[8], 3'h2}, 7, 0, rx);
        host.xfer(a[7:0], 7, 0, rx);
        for (int i = 0; i < n; i++) begin
            host.xfer(dat(a, i), 7, 0, rx);
            if (ok)
                shadow[{a[8:2], a[1:0] + 2'(i)}] = dat(a, i);
        end
        if (tail > 0)
            host.xfer(8'h96, 7, 8 - tail, rx);
        host.desel();
        chk(write_busy, ok, "busy start");
        if (ok) begin
            status();
            chk(st, 8'hff, "status while busy");
        end
        wait_idle();
        chk(write_latch, ok ? 1'b0 : l, "latch after write");
    endtask
    task automatic rd(input logic [8:0] a, input int n, input bit hold);
        host.sel();
        host.xfer({4'h0, a[8], 3'h3}, 7, 0, rx);
        host.xfer(a[7:0], 7, 0, rx);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'hff, 7, 4, rx);
            if (hold && i == n - 1)
                host.pause();
            host.xfer(8'hff, 3, 0, rx);
            chk(rx, shadow[9'(a + 9'(i))], "read data");
        end
        host.desel();
        chk(so_oe, 1'b0, "so released");
    endtask
    initial begin
        srst = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 srst = 1'b0;
        // select held low through reset, so no fall has been seen yet
        host.xfer(8'h06, 7, 0, rx);
        host.desel();
        chk(write_latch, 1'b0, "latch without select fall");
        cmd(8'h06);
        chk(write_latch, 1'b1, "latch set");
        status();
        chk(st, 8'h02, "idle status");
        cmd(8'h04);
        chk(write_latch, 1'b0, "latch clear");
        wr(9'h020, 1, 0, 1'b0, 1);
        wr(9'h020, 1, 0, 1'b0, 2);
        cmd(8'h06);
        srst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk(write_latch, 1'b0, "latch after reset");
        wr(9'h10e, 5, 0, 1'b1, 0);
        rd(9'h10c, 4, 1'b0);
        wr(9'h104, 1, 3, 1'b0, 0);
        wr(9'h104, 0, 0, 1'b0, 0);
        for (int lv = 0; lv < 4; lv++) begin
            sw(2'(lv));
            wr(9'h07c, 1, 0, lv < 3, 0);
            wr(9'h17c, 1, 0, lv < 2, 0);
            wr(9'h180, 1, 0, lv == 0, 0);
        end
        rd(9'h07c, 1, 1'b0);
        sw(2'h0);
        wr(9'h1ff, 1, 0, 1'b1, 0);
        wr(9'h000, 1, 0, 1'b1, 0);
        rd(9'h1ff, 2, 1'b1);
        summarize();
    end
endmodule
bind spi_eeprom_core spi_eeprom_core_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props (
    .ref_clk(ref_clk), .srst(srst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .so(so),
    .so_oe(so_oe), .write_busy(write_busy), .write_latch(write_latch),
    .protect_level(protect_level));
